// ### src/external_bus_unit.sv
// expansion port controller: bus control register, area decode, wait states
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module external_bus_unit #(
  parameter int ADDR_W = 8,
  parameter logic [4:0] DYN_WAITS = 5'h01
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic accReq,
  input wire logic [23:0] accAddr,
  input wire logic [1:0] accSpace,
  input wire logic accRmw,
  output logic accDone,
  input wire logic busGrant,
  output logic busRequestOut,
  output logic busLockOut,
  output logic [23:0] memAddr,
  output logic memDynamic,
  output logic memActive,
  output logic memRelease
);
  typedef struct packed {
    logic [23:0] ctrl;
    logic [ext_bus_pkg::NUM_AREAS-1:0][23:0] attr;
    logic awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    ext_bus_pkg::phase_t phase;
    logic [4:0] curWaits;
    logic [1:0] curTrail;
    logic curRmw;
    logic master;
    logic [23:0] addr;
    logic dyn;
  } unit_t;
  unit_t st;
  unit_t next_st;

  logic [ext_bus_pkg::NUM_AREAS-1:0] hit;
  logic [ext_bus_pkg::NUM_AREAS-1:0] dynArea;
  logic [4:0] selWaits;
  logic selDyn;
  logic [1:0] selTrail;
  logic start;
  logic waitLast;
  logic trailLast;
  logic [31:0] merged;
  logic [5:0] wIdx;
  logic [5:0] rIdx;

  // one comparator per attribute-defined area
  for (genvar g = 0; g < ext_bus_pkg::NUM_AREAS; g++) begin : g_area
    area_match u_match (
      .attr(st.attr[g]),
      .addr(accAddr),
      .space(accSpace),
      .hit(hit[g]),
      .dynamic(dynArea[g])
    );
  end

  // pick the wait count of the lowest numbered hit, else the default area
  always_comb begin
    selDyn = 1'b0;
    selWaits = st.ctrl[ext_bus_pkg::DEFAULT_LSB +: 5];
    if (hit[0]) begin
      selDyn = dynArea[0];
      selWaits = st.ctrl[ext_bus_pkg::AREA0_LSB +: 5];
    end else if (hit[1]) begin
      selDyn = dynArea[1];
      selWaits = st.ctrl[ext_bus_pkg::AREA1_LSB +: 5];
    end else if (hit[2]) begin
      selDyn = dynArea[2];
      selWaits = {2'b00, st.ctrl[ext_bus_pkg::AREA2_LSB +: 3]};
    end else if (hit[3]) begin
      selDyn = dynArea[3];
      selWaits = {2'b00, st.ctrl[ext_bus_pkg::AREA3_LSB +: 3]};
    end
    if (selDyn) begin
      selWaits = DYN_WAITS; // dynamic accesses ignore the wait fields
      selTrail = 2'h0;
    end else if (selWaits >= ext_bus_pkg::TRAIL_TWO_MIN) begin
      selTrail = 2'h2;
    end else if (selWaits >= ext_bus_pkg::TRAIL_ONE_MIN) begin
      selTrail = 2'h1;
    end else begin
      selTrail = 2'h0;
    end
  end

  // the next access begins only from idle, with mastership held
  assign start = (st.phase == ext_bus_pkg::PH_IDLE) && accReq && busGrant;

  wait_timer #(.WIDTH(5)) u_access (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .load(start),
    .loadValue(selWaits),
    .last(waitLast)
  );

  wait_timer #(.WIDTH(2)) u_trail (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .load(accDone && (st.curTrail != 2'h0)),
    .loadValue(st.curTrail),
    .last(trailLast)
  );

  // byte-lane merge of held write data
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      merged[8*b +: 8] = st.wStrb[b] ? st.wData[8*b +: 8] : 8'h00;
    end
    wIdx = st.awAddr[7:2];
    rIdx = s_axi_araddr[7:2];
  end

  // register slave, access sequencer and mastership tracking
  always_comb begin
    logic [23:0] old;
    old = 24'h000000;
    next_st = st;
    next_st.master = busGrant;
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.wHeld = 1'b1;
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
    end
    if (st.awHeld && st.wHeld && !st.bvalid) begin
      next_st.awHeld = 1'b0;
      next_st.wHeld = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = ext_bus_pkg::RESP_OKAY;
      if (wIdx == ext_bus_pkg::ADDR_CTRL[7:2]) begin
        old = st.ctrl;
        for (int b = 0; b < 3; b++) begin
          if (st.wStrb[b]) old[8*b +: 8] = merged[8*b +: 8];
        end
        old[ext_bus_pkg::MASTER_STATE_BIT] = 1'b0;
        next_st.ctrl = old;
      end else if (wIdx inside {[ext_bus_pkg::ADDR_ATTR0[7:2]:ext_bus_pkg::ADDR_ATTR3[7:2]]}) begin
        old = st.attr[wIdx[1:0] - 2'h1];
        for (int b = 0; b < 3; b++) begin
          if (st.wStrb[b]) old[8*b +: 8] = merged[8*b +: 8];
        end
        next_st.attr[wIdx[1:0] - 2'h1] = old;
      end else begin
        next_st.bresp = ext_bus_pkg::RESP_SLVERR;
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = ext_bus_pkg::RESP_OKAY;
      next_st.rdata = 32'h00000000;
      if (rIdx == ext_bus_pkg::ADDR_CTRL[7:2]) begin
        next_st.rdata = {8'h00, st.ctrl};
        next_st.rdata[ext_bus_pkg::MASTER_STATE_BIT] = st.master;
      end else if (rIdx inside {[ext_bus_pkg::ADDR_ATTR0[7:2]:ext_bus_pkg::ADDR_ATTR3[7:2]]}) begin
        next_st.rdata = {8'h00, st.attr[rIdx[1:0] - 2'h1]};
      end else begin
        next_st.rresp = ext_bus_pkg::RESP_SLVERR;
      end
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    unique case (st.phase)
      ext_bus_pkg::PH_IDLE: begin
        if (start) begin
          next_st.phase = ext_bus_pkg::PH_ACCESS;
          next_st.curWaits = selWaits;
          next_st.curTrail = selTrail;
          next_st.curRmw = accRmw;
          next_st.addr = accAddr;
          next_st.dyn = selDyn;
        end
      end
      ext_bus_pkg::PH_ACCESS: begin
        if (waitLast) begin
          next_st.phase = (st.curTrail != 2'h0) ? ext_bus_pkg::PH_TRAIL : ext_bus_pkg::PH_IDLE;
          if (st.curTrail == 2'h0) next_st.curRmw = 1'b0;
        end
      end
      ext_bus_pkg::PH_TRAIL: begin
        if (trailLast) begin
          next_st.phase = ext_bus_pkg::PH_IDLE;
          next_st.curRmw = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.ctrl <= ext_bus_pkg::CTRL_RESET;
      st.attr <= {ext_bus_pkg::NUM_AREAS{ext_bus_pkg::ATTR_RESET}};
    end else begin
      st <= next_st;
    end
  end

  // bus slave handshakes: one write and one read in flight
  assign s_axi_awready = !st.awHeld && !st.bvalid;
  assign s_axi_wready = !st.wHeld && !st.bvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

  // expansion port pins; the transfer completes at the last wait state
  assign accDone = (st.phase == ext_bus_pkg::PH_ACCESS) && waitLast;
  assign memActive = (st.phase == ext_bus_pkg::PH_ACCESS);
  assign memRelease = (st.phase == ext_bus_pkg::PH_TRAIL);
  assign memAddr = st.addr;
  assign memDynamic = st.dyn;
  assign busRequestOut = st.ctrl[ext_bus_pkg::REQ_HOLD_BIT] || accReq
    || (st.phase != ext_bus_pkg::PH_IDLE);
  assign busLockOut = st.ctrl[ext_bus_pkg::LOCK_HOLD_BIT] || (accReq && accRmw)
    || st.curRmw;

  // helper counters for the checks below
  logic [5:0] accCycles;
  logic [2:0] trailCycles;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      accCycles <= 6'h00;
      trailCycles <= 3'h0;
    end else begin
      accCycles <= memActive ? accCycles + 6'h01 : 6'h00;
      trailCycles <= memRelease ? trailCycles + 3'h1 : 3'h0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_finish;
    accDone ##1 memRelease;
  endsequence

  property p_req_hold;
    st.ctrl[ext_bus_pkg::REQ_HOLD_BIT] |-> busRequestOut;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request hold not honoured");

  property p_lock_hold;
    st.ctrl[ext_bus_pkg::LOCK_HOLD_BIT] |-> busLockOut;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock hold not honoured");

  property p_master_flag;
    (s_axi_arvalid && s_axi_arready && rIdx == 6'h00) |=>
      s_axi_rdata[ext_bus_pkg::MASTER_STATE_BIT] == $past(busGrant, 2);
  endproperty
  a_master_flag: assert property (p_master_flag) else $error("master flag mismatch");

  property p_wait_count;
    accDone |-> (accCycles + 6'h01) == {1'b0, st.curWaits};
  endproperty
  a_wait_count: assert property (p_wait_count) else $error("wrong wait state count");

  property p_small_no_trail;
    (accDone && st.curWaits < ext_bus_pkg::TRAIL_ONE_MIN) |=> !memRelease;
  endproperty
  a_small_no_trail: assert property (p_small_no_trail) else $error("unexpected trail");

  property p_one_trail;
    (accDone && !st.dyn && st.curWaits >= ext_bus_pkg::TRAIL_ONE_MIN
      && st.curWaits < ext_bus_pkg::TRAIL_TWO_MIN) |-> s_finish ##1 !memRelease;
  endproperty
  a_one_trail: assert property (p_one_trail) else $error("need one trailing state");

  property p_two_trail;
    (accDone && st.curWaits >= ext_bus_pkg::TRAIL_TWO_MIN && !st.dyn)
      |-> s_finish ##1 memRelease ##1 !memRelease;
  endproperty
  a_two_trail: assert property (p_two_trail) else $error("need two trailing states");

  property p_trail_apart;
    memRelease |-> !memActive && !accDone && trailCycles < 3'h2;
  endproperty
  a_trail_apart: assert property (p_trail_apart) else $error("trail overlaps access");

  property p_no_start_in_trail;
    memRelease |=> !(memActive && $rose(memActive));
  endproperty
  a_no_start_in_trail: assert property (p_no_start_in_trail) else $error("trail start");

  property p_start_needs_grant;
    $rose(memActive) |-> $past(busGrant) && $past(accReq);
  endproperty
  a_start_needs_grant: assert property (p_start_needs_grant) else $error("no grant");
endmodule : external_bus_unit
`default_nettype wire

// ### src/ext_bus_pkg.sv
// constants and types shared by the expansion bus wait-state controller
package ext_bus_pkg;
  // register byte addresses on the AXI4-Lite slave
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ATTR0 = 8'h04;
  localparam logic [7:0] ADDR_ATTR1 = 8'h08;
  localparam logic [7:0] ADDR_ATTR2 = 8'h0C;
  localparam logic [7:0] ADDR_ATTR3 = 8'h10;
  localparam int NUM_AREAS = 4;
  // bus_control field positions
  localparam int REQ_HOLD_BIT = 23;
  localparam int LOCK_HOLD_BIT = 22;
  localparam int MASTER_STATE_BIT = 21;
  localparam int DEFAULT_LSB = 16;
  localparam int AREA3_LSB = 13;
  localparam int AREA2_LSB = 10;
  localparam int AREA1_LSB = 5;
  localparam int AREA0_LSB = 0;
  localparam logic [23:0] CTRL_RESET = 24'h1FFFFF;
  // area_attribute_reg field positions
  localparam int ATTR_BASE_LSB = 12;
  localparam int ATTR_COUNT_LSB = 8;
  localparam int ATTR_DYN_BIT = 3;
  localparam logic [23:0] ATTR_RESET = 24'h000000;
  // memory space codes on the access port
  localparam logic [1:0] SPACE_X = 2'h0;
  localparam logic [1:0] SPACE_Y = 2'h1;
  localparam logic [1:0] SPACE_P = 2'h2;
  // trailing wait thresholds
  localparam logic [4:0] TRAIL_ONE_MIN = 5'h04;
  localparam logic [4:0] TRAIL_TWO_MIN = 5'h08;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {PH_IDLE, PH_ACCESS, PH_TRAIL} phase_t;
endpackage : ext_bus_pkg

// ### src/area_match.sv
// address comparator for one attribute-defined area
`timescale 1ns/1ps
`default_nettype none
module area_match (
  input wire logic [23:0] attr,
  input wire logic [23:0] addr,
  input wire logic [1:0] space,
  output logic hit,
  output logic dynamic
);
  logic [11:0] mask;
  logic [3:0] count;
  logic spaceOn;

  // compare the top 'count' address bits against the programmed base
  always_comb begin
    count = attr[ext_bus_pkg::ATTR_COUNT_LSB +: 4];
    for (int i = 0; i < 12; i++) begin
      mask[i] = (32'(i) >= 32'(12) - 32'(count));
    end
    unique case (space)
      ext_bus_pkg::SPACE_X: spaceOn = attr[0];
      ext_bus_pkg::SPACE_Y: spaceOn = attr[1];
      ext_bus_pkg::SPACE_P: spaceOn = attr[2];
      default: spaceOn = 1'b0;
    endcase
    hit = spaceOn && (((addr[23:12] ^ attr[ext_bus_pkg::ATTR_BASE_LSB +: 12]) & mask) == 12'h000);
    dynamic = attr[ext_bus_pkg::ATTR_DYN_BIT];
  end
endmodule : area_match
`default_nettype wire

// ### src/wait_timer.sv
// loadable down-counter marking the last of a run of wait cycles
`timescale 1ns/1ps
`default_nettype none
module wait_timer #(
  parameter int WIDTH = 5
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  output logic last
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } timer_t;
  timer_t st;
  timer_t next_st;

  // load wins; otherwise count down to zero and stop
  always_comb begin
    next_st = st;
    if (load) begin
      next_st.count = loadValue;
    end else if (st.count != '0) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign last = (st.count == WIDTH'(1));
endmodule : wait_timer
`default_nettype wire

// ### bench/bus_arbiter_model.sv
// external bus arbiter: grants mastership a programmable number of cycles after request
`timescale 1ns/1ps
`default_nettype none
module bus_arbiter_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic busRequestOut,
  input wire logic [1:0] grantDelay,
  output logic busGrant
);
  logic [1:0] waitCount;
  // grant after the delay, withdraw as soon as the request goes away
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busGrant <= 1'b0;
      waitCount <= 2'h0;
    end else if (busRequestOut !== 1'b1) begin
      busGrant <= 1'b0;
      waitCount <= 2'h0;
    end else if (waitCount >= grantDelay) begin
      busGrant <= 1'b1;
    end else begin
      waitCount <= waitCount + 2'h1;
    end
  end
endmodule : bus_arbiter_model
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the expansion bus wait-state controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [31:0] ctrl; logic [23:0] addr; logic [1:0] sp; int n; int t;
  } row_t;
  logic core_clk = 1'b0, arst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp, accSpace = 2'h0, grantDelay = 2'h0;
  logic awready, wready, bvalid, arready, rvalid, accDone, busGrant;
  logic accReq = 1'b0, accRmw = 1'b0, busRequestOut, busLockOut;
  logic memDynamic, memActive, memRelease;
  logic [23:0] accAddr = 24'h0, memAddr;
  logic [31:0] rd;
  logic [1:0] rs;
  int mismatches = 0, nChecks = 0, na, nr, nd, nl, nq, i;
  row_t rows [9] = '{
    '{32'h00012424, 24'h100123, 2'h0, 4, 1}, '{32'h00012428, 24'h100123, 2'h0, 8, 2},
    '{32'h00012423, 24'h100123, 2'h0, 3, 0}, '{32'h000124E1, 24'h200000, 2'h1, 7, 1},
    '{32'h00013421, 24'h300000, 2'h2, 5, 1}, '{32'h00014421, 24'h400000, 2'h0, 2, 0},
    '{32'h00092421, 24'h500000, 2'h0, 9, 2}, '{32'h00052421, 24'h100123, 2'h1, 5, 1},
    '{32'h00012421, 24'h500000, 2'h0, 1, 0}};

  always #12.5 core_clk = ~core_clk;

  external_bus_unit DUT (.core_clk(core_clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .accReq(accReq),
    .accAddr(accAddr), .accSpace(accSpace), .accRmw(accRmw), .accDone(accDone),
    .busGrant(busGrant), .busRequestOut(busRequestOut), .busLockOut(busLockOut),
    .memAddr(memAddr), .memDynamic(memDynamic), .memActive(memActive),
    .memRelease(memRelease));
  bus_arbiter_model arbiter (.core_clk(core_clk), .arst_n(arst_n),
    .busRequestOut(busRequestOut), .grantDelay(grantDelay), .busGrant(busGrant));

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_count(input int got, input int exp);
    nChecks++;
    if (got != exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_count

  // write cycle: address and data offered together, each dropped when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    // wait for the answer however long it takes; only the watchdog ends a hang
    forever begin
      @(posedge core_clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp; bready <= 1'b0; break;
      end
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata; r = rresp; rready <= 1'b0; break;
      end
    end
  endtask : axi_read

  // one external access: counts wait, done position, trailing, lock and request cycles
  task automatic do_access(input logic [23:0] a, input logic [1:0] sp, input logic rmw);
    bit seen;
    int k;
    seen = 0; na = 0; nr = 0; nd = -1; nl = 0; nq = 0;
    @(posedge core_clk);
    accReq <= 1'b1; accAddr <= a; accSpace <= sp; accRmw <= rmw;
    for (k = 0; k < 200; k++) begin
      @(negedge core_clk);
      if (memActive === 1'b1) na++;
      if (memRelease === 1'b1) nr++;
      if ((memActive | memRelease) === 1'b1 && busLockOut === 1'b1) nl++;
      if ((memActive | memRelease) === 1'b1 && busRequestOut === 1'b1) nq++;
      if (accDone === 1'b1) begin
        nd = na; seen = 1;
        @(posedge core_clk);
        accReq <= 1'b0;
      end else if (seen && memActive !== 1'b1 && memRelease !== 1'b1) break;
    end
  endtask : do_access

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    #(25 * 20000);
    mismatches++;
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    axi_read(ext_bus_pkg::ADDR_CTRL, rd, rs);
    check_word(rd, 32'h001FFFFF);
    // areas 0..3 each match twelve address bits, one space each
    axi_write(ext_bus_pkg::ADDR_ATTR0, 32'h00100C01, rs);
    axi_write(ext_bus_pkg::ADDR_ATTR1, 32'h00200C02, rs);
    axi_write(ext_bus_pkg::ADDR_ATTR2, 32'h00300C04, rs);
    axi_write(ext_bus_pkg::ADDR_ATTR3, 32'h00400C01, rs);
    // table of static accesses across areas, default and boundaries
    for (i = 0; i < 9; i++) begin
      grantDelay <= i[1:0];
      axi_write(ext_bus_pkg::ADDR_CTRL, rows[i].ctrl, rs);
      do_access(rows[i].addr, rows[i].sp, 1'b0);
      check_count(na, rows[i].n);
      check_count(nd, rows[i].n);
      check_count(nr, rows[i].t);
      check_count(nl, 0);
      check_count(nq, na + nr);
      check_word({7'h0, memDynamic, memAddr}, {8'h00, rows[i].addr});
    end
    // read-modify-write keeps lock through five waits and one trailing state
    axi_write(ext_bus_pkg::ADDR_CTRL, 32'h00052421, rs);
    do_access(24'h100123, 2'h1, 1'b1);
    check_count(nl, 6);
    check_word({30'h0, busRequestOut, busLockOut}, 32'h0);
    // dynamic area 3 ignores its wait field, adds no trailing state, lock ends with it
    axi_write(ext_bus_pkg::ADDR_CTRL, 32'h0001E421, rs);
    axi_write(ext_bus_pkg::ADDR_ATTR3, 32'h00400C09, rs);
    do_access(24'h400000, 2'h0, 1'b1);
    check_count(na, 1);
    check_count(nr, 0);
    check_count(nl, 1);
    check_word({7'h0, memDynamic, memAddr}, 32'h01400000);
    // hold bits drive request and lock with no access; master flag follows grant
    axi_write(ext_bus_pkg::ADDR_CTRL, 32'hFFE12421, rs);
    repeat (6) @(posedge core_clk);
    check_word({30'h0, busRequestOut, busLockOut}, 32'h3);
    axi_read(ext_bus_pkg::ADDR_CTRL, rd, rs);
    check_word(rd, 32'h00E12421);
    axi_write(ext_bus_pkg::ADDR_CTRL, 32'h00212421, rs);
    repeat (4) @(posedge core_clk);
    axi_read(ext_bus_pkg::ADDR_CTRL, rd, rs);
    check_word(rd, 32'h00012421);
    check_word({30'h0, busRequestOut, busLockOut}, 32'h0);
    // unmapped address refused both ways
    axi_write(8'h20, 32'h0, rs);
    check_word({30'h0, rs}, {30'h0, ext_bus_pkg::RESP_SLVERR});
    axi_read(8'h20, rd, rs);
    check_word({rd[29:0], rs}, {30'h0, ext_bus_pkg::RESP_SLVERR});
    // asynchronous reset mid-run restores the wait fields
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    axi_read(ext_bus_pkg::ADDR_CTRL, rd, rs);
    check_word(rd, 32'h001FFFFF);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
